// ---- src/scd_clock_divider.sv ----
// smart card clock generator: divides the reference clock by 1, 2 or 4
// or holds the card clock low, as set by the serial command byte.
// assumes all pins but reset are asynchronous to mclk, the reference stays at or
// below 20 MHz and each serial clock phase lasts at least 4 mclk periods.

// How it works
// - codes 00 hold card clock low; 01, 10, 11 divide reference by 1, 2, 4.
// - a new ratio is taken only when the last divider stage starts a period.
// - a ratio change reaches the card clock within four reference pulses.
// - divide by one copies the reference; its duty cycle passes straight through.
// - slow or fast edge rate from the command byte, changeable at any time.
// - every accepted command byte drives card reset from its bit four.
// - command bits are shifted in only while chip select is low.
// - a full byte is latched and applied on the chip select rising edge.
module scd_clock_divider
  import scd_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ref_clk_in,
  input wire logic spi_clk_in,
  input wire logic spi_mosi_in,
  input wire logic spi_cs_n_in,
  output logic card_clock_out,
  output logic card_reset_out,
  output logic slow_edge_rate,
  output logic fast_edge_rate,
  output logic ratio_pending
);

  logic ref_lvl;
  logic sclk_lvl;
  logic mosi_lvl;
  logic cs_n_lvl;

  scd_sync3 #(.INIT(1'b0)) u_sync_ref (
    .mclk(mclk),
    .reset(reset),
    .pin_in(ref_clk_in),
    .level_ff(ref_lvl)
  );

  scd_sync3 #(.INIT(1'b0)) u_sync_sclk (
    .mclk(mclk),
    .reset(reset),
    .pin_in(spi_clk_in),
    .level_ff(sclk_lvl)
  );

  scd_sync3 #(.INIT(1'b0)) u_sync_mosi (
    .mclk(mclk),
    .reset(reset),
    .pin_in(spi_mosi_in),
    .level_ff(mosi_lvl)
  );

  scd_sync3 #(.INIT(1'b1)) u_sync_cs (
    .mclk(mclk),
    .reset(reset),
    .pin_in(spi_cs_n_in),
    .level_ff(cs_n_lvl)
  );

  // edge detection on the filtered levels
  logic ref_prev_ff;
  logic sclk_prev_ff;
  logic cs_n_prev_ff;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ref_prev_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
      cs_n_prev_ff <= 1'b1;
    end else begin
      ref_prev_ff <= ref_lvl;
      sclk_prev_ff <= sclk_lvl;
      cs_n_prev_ff <= cs_n_lvl;
    end
  end

  wire ref_rise = ref_lvl & ~ref_prev_ff;
  wire ref_fall = ~ref_lvl & ref_prev_ff;
  wire sclk_rise = sclk_lvl & ~sclk_prev_ff;
  wire cs_fall = ~cs_n_lvl & cs_n_prev_ff;
  wire cs_rise = cs_n_lvl & ~cs_n_prev_ff;

  // serial command receiver
  logic [7:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] nxt_shift;
  logic [3:0] nxt_bit_cnt;

  wire shift_en = sclk_rise & ~cs_n_lvl;
  wire byte_full = (bit_cnt_ff >= 4'(BYTE_BITS));
  // a frame holding several bytes applies the last eight bits seen
  wire latch_byte = cs_rise & byte_full;

  assign nxt_shift = cs_fall ? RST_BYTE :
                     shift_en ? {shift_ff[6:0], mosi_lvl} : shift_ff;
  assign nxt_bit_cnt = cs_fall ? RST_BIT_COUNT :
                       (shift_en & ~byte_full) ? bit_cnt_ff + 4'h1 :
                       bit_cnt_ff;

  always_ff @(posedge mclk) begin
    if (reset) begin
      shift_ff <= RST_BYTE;
      bit_cnt_ff <= RST_BIT_COUNT;
    end else begin
      shift_ff <= nxt_shift;
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  // applied settings
  logic [1:0] ratio_req_ff;
  logic edge_fast_ff;
  logic card_rst_ff;

  wire [1:0] byte_ratio = {shift_ff[BIT_RATIO_LO], shift_ff[BIT_RATIO_HI]};

  always_ff @(posedge mclk) begin
    if (reset) begin
      ratio_req_ff <= RST_RATIO;
      edge_fast_ff <= RST_EDGE_FAST;
      card_rst_ff <= RST_CARD_RST;
    end else if (latch_byte) begin
      ratio_req_ff <= byte_ratio;
      edge_fast_ff <= shift_ff[BIT_EDGE_FAST];
      card_rst_ff <= shift_ff[BIT_CARD_RST];
    end
  end

  // divider; the count advances on reference rises, 1 starts a high phase
  logic [1:0] ratio_act_ff;
  logic [1:0] div_cnt_ff;
  logic [1:0] nxt_ratio_act;
  logic [1:0] nxt_div_cnt;
  logic nxt_card_clock;

  // swap only while the card clock is low and a period is about to begin,
  // so no half period is ever cut short
  wire at_boundary = (div_cnt_ff == RST_DIV_COUNT) |
                     (ratio_act_ff == RATIO_HOLD);
  wire apply_ratio = ref_fall & at_boundary &
                     (ratio_req_ff != ratio_act_ff);
  wire [1:0] cnt_step = (ratio_act_ff == RATIO_DIV2) ?
                        {1'b0, ~div_cnt_ff[0]} : div_cnt_ff + 2'h1;
  wire cnt_run = (ratio_act_ff == RATIO_DIV2) |
                 (ratio_act_ff == RATIO_DIV4);

  assign nxt_ratio_act = apply_ratio ? ratio_req_ff : ratio_act_ff;
  assign nxt_div_cnt = apply_ratio ? RST_DIV_COUNT :
                       (ref_rise & cnt_run) ? cnt_step : div_cnt_ff;

  // high for counts 1 and 2 at divide by four, count 1 at divide by two
  always_comb begin
    case (ratio_act_ff)
      RATIO_HOLD: nxt_card_clock = 1'b0;
      RATIO_DIV1: nxt_card_clock = ref_lvl;
      RATIO_DIV2: nxt_card_clock = div_cnt_ff[0];
      RATIO_DIV4: nxt_card_clock = div_cnt_ff[0] ^ div_cnt_ff[1];
      default: nxt_card_clock = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ratio_act_ff <= RST_RATIO;
      div_cnt_ff <= RST_DIV_COUNT;
    end else begin
      ratio_act_ff <= nxt_ratio_act;
      div_cnt_ff <= nxt_div_cnt;
    end
  end

  // outputs, all registered
  always_ff @(posedge mclk) begin
    if (reset) begin
      card_clock_out <= 1'b0;
      card_reset_out <= RST_CARD_RST;
      fast_edge_rate <= RST_EDGE_FAST;
      slow_edge_rate <= ~RST_EDGE_FAST;
      ratio_pending <= 1'b0;
    end else begin
      card_clock_out <= nxt_card_clock;
      card_reset_out <= card_rst_ff;
      fast_edge_rate <= edge_fast_ff;
      slow_edge_rate <= ~edge_fast_ff;
      ratio_pending <= (ratio_req_ff != nxt_ratio_act);
    end
  end

  // helper: reference pulses seen while a ratio change waits
  logic [2:0] wait_pulses_ff;

  always_ff @(posedge mclk) begin
    if (reset) begin
      wait_pulses_ff <= 3'h0;
    end else if (ratio_req_ff == ratio_act_ff || latch_byte) begin
      // a fresh request restarts the allowance of four pulses
      wait_pulses_ff <= 3'h0;
    end else if (ref_fall && wait_pulses_ff != 3'h7) begin
      wait_pulses_ff <= wait_pulses_ff + 3'h1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  chk_hold_low_out: assert property (
    $past(ratio_act_ff) == RATIO_HOLD |-> !card_clock_out)
    else $error("card clock not low in hold");

  chk_div1_follow: assert property (
    $past(ratio_act_ff) == RATIO_DIV1 |-> card_clock_out == $past(ref_lvl))
    else $error("divide by one does not follow reference");

  chk_ratio_sync: assert property (
    ratio_act_ff != $past(ratio_act_ff)
      |-> $past(ref_fall) && $past(at_boundary) && !card_clock_out)
    else $error("ratio applied off a period boundary");

  chk_apply_delay: assert property (
    wait_pulses_ff <= 3'(APPLY_MAX_PULSES))
    else $error("ratio change waited more than four pulses");

  chk_edge_rate: assert property (
    latch_byte |=> ##1 fast_edge_rate == $past(shift_ff[BIT_EDGE_FAST], 2)
      && slow_edge_rate != fast_edge_rate)
    else $error("edge rate not taken from command byte");

  chk_card_reset: assert property (
    latch_byte |=> ##1 card_reset_out == $past(shift_ff[BIT_CARD_RST], 2))
    else $error("card reset not taken from bit four");

  chk_cs_gate: assert property (
    cs_n_lvl && $past(cs_n_lvl) |-> $stable(shift_ff))
    else $error("shift register moved with chip select high");

  chk_latch_edge: assert property (
    ratio_req_ff != $past(ratio_req_ff) |-> $past(cs_rise && byte_full))
    else $error("settings changed outside chip select rise");

  chk_restart_zero: assert property (
    $past(ratio_act_ff) == RATIO_HOLD && ratio_act_ff != RATIO_HOLD
      |-> div_cnt_ff == RST_DIV_COUNT)
    else $error("divider did not restart from zero");

endmodule : scd_clock_divider

// ---- src/scd_pkg.sv ----
// constants of the smart card clock divider: ratio codes, command byte
// layout, reset values and timing figures.
// assumes a single 100 MHz system clock, mclk, in the using modules.
package scd_pkg;

  // system clock
  localparam int MCLK_MHZ = 100;
  localparam int MCLK_PERIOD_NS = 10;

  // reference input limit; the 3-flop sampler needs several mclk per phase
  localparam int REF_MAX_MHZ = 20;
  localparam int REF_MIN_SAMPLES = MCLK_MHZ / (2 * REF_MAX_MHZ);

  // ratio field codes, written as {ratio_select_lo, ratio_select_hi}
  localparam logic [1:0] RATIO_HOLD = 2'h0;
  localparam logic [1:0] RATIO_DIV1 = 2'h1;
  localparam logic [1:0] RATIO_DIV2 = 2'h2;
  localparam logic [1:0] RATIO_DIV4 = 2'h3;

  // serial command byte layout
  localparam int BYTE_BITS = 8;
  localparam int BIT_RATIO_LO = 0;
  localparam int BIT_RATIO_HI = 1;
  localparam int BIT_EDGE_FAST = 3;
  localparam int BIT_CARD_RST = 4;

  // longest delay of a ratio change, in reference pulses
  localparam int APPLY_MAX_PULSES = 4;

  // reset values
  localparam logic [1:0] RST_RATIO = RATIO_HOLD;
  localparam logic RST_EDGE_FAST = 1'b0;
  localparam logic RST_CARD_RST = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_DIV_COUNT = 2'h0;
  localparam logic [3:0] RST_BIT_COUNT = 4'h0;

endpackage : scd_pkg

// ---- src/scd_sync3.sv ----
// three-flop sampler for one pin that is asynchronous to mclk.
// assumes the pin holds each level for at least two mclk periods.
module scd_sync3 #(
  parameter logic INIT = 1'b0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic pin_in,
  output logic level_ff
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // s1 feeds s2 only; the filter looks at the later two stages
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
      level_ff <= INIT;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end

endmodule : scd_sync3

// ---- tb/scd_card_model.sv ----
// card clock contact model: measures the last high and low phase lengths
// assumes the card clock is a registered level, sampled on mclk
module scd_card_model (
  input wire logic mclk,
  input wire logic card_clock_out,
  output logic [7:0] high_len,
  output logic [7:0] low_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] run_ff = 8'h00;
  logic last_ff = 1'b0;
  wire logic flip = card_clock_out != last_ff;
  // a card must see both phases whole, so lengths count mclk samples
  always_ff @(posedge mclk) begin
    last_ff <= card_clock_out;
    run_ff <= flip ? 8'h01 : run_ff + 8'h01;
    if (flip && last_ff) high_len <= run_ff;
    if (flip && !last_ff) low_len <= run_ff;
  end
endmodule : scd_card_model

// ---- tb/tb_top.sv ----
// self-checking bench of the card clock divider
// assumes scd_pkg; reference made here at 10 MHz, serial port bit-banged
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scd_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ref_clk = 1'b0;
  logic sclk = 1'b0;
  logic mosi = 1'b0;
  logic cs_n = 1'b1;
  logic card_clk, card_rst, slow, fast, pending;
  logic [7:0] high_len, low_len, last_b, b;
  logic [31:0] lfsr = 32'hED85;
  logic [2:0] ref_cnt = 3'h0;
  logic [1:0] code;
  logic seen;
  int error_cnt = 0;
  int checks_done = 0;
  always #5 mclk = ~mclk;
  // 10 MHz, 50% duty: inside the duty window and below the card limit
  always @(posedge mclk) begin
    ref_cnt <= (ref_cnt == 3'h4) ? 3'h0 : ref_cnt + 3'h1;
    if (ref_cnt == 3'h4) ref_clk <= ~ref_clk;
  end
  scd_clock_divider i_scd_clock_divider (.mclk(mclk), .reset(reset),
    .ref_clk_in(ref_clk), .spi_clk_in(sclk), .spi_mosi_in(mosi),
    .spi_cs_n_in(cs_n), .card_clock_out(card_clk),
    .card_reset_out(card_rst), .slow_edge_rate(slow),
    .fast_edge_rate(fast), .ratio_pending(pending));
  scd_card_model i_scd_card_model (.mclk(mclk), .card_clock_out(card_clk),
    .high_len(high_len), .low_len(low_len));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [7:0] phase_len(input logic [1:0] c);
    return (c == RATIO_DIV1) ? 8'h05 : (c == RATIO_DIV2) ? 8'h0A : 8'h14;
  endfunction : phase_len
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle
  task automatic results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_bit
  // msb first; a short frame carries the top bits only
  task automatic send_frame(input logic [7:0] v, input int nbits);
    cs_n <= 1'b0;
    idle(8);
    for (int i = 0; i < nbits; i++) begin
      mosi <= v[7 - i];
      sclk <= 1'b0;
      idle(8);
      sclk <= 1'b1;
      idle(8);
    end
    sclk <= 1'b0;
    idle(8);
    cs_n <= 1'b1;
    idle(16);
  endtask : send_frame
  task automatic chk_settings(input logic [7:0] v);
    cmp_bit(fast, v[BIT_EDGE_FAST]);
    cmp_bit(slow, !v[BIT_EDGE_FAST]);
    cmp_bit(card_rst, v[BIT_CARD_RST]);
  endtask : chk_settings
  initial begin
    idle(12);
    reset <= 1'b0;
    idle(8);
    cmp_bit(card_clk, 1'b0);
    chk_settings(8'h00);
    for (int k = 0; k < 9; k++) begin
      lfsr = lfsr_next(lfsr);
      code = (k % 4 == 3) ? RATIO_HOLD : 2'(1 + k % 3);
      b = lfsr[7:0];
      b[BIT_RATIO_LO] = code[1];
      b[BIT_RATIO_HI] = code[0];
      send_frame(b, 8);
      chk_settings(b);
      last_b = b;
      // the change must land within four reference pulses
      // ref period is 10 mclk; the watch starts 11 mclk after the latch
      for (int t = 0; pending !== 1'b0; t++) begin
        if (t == APPLY_MAX_PULSES * 10 - 8) begin
          error_cnt++;
          results();
        end
        idle(1);
      end
      seen = 1'b0;
      for (int t = 0; t < 100; t++) begin
        idle(1);
        seen = seen | card_clk;
      end
      if (code == RATIO_HOLD) begin
        cmp_bit(seen, 1'b0);
      end else begin
        cmp(high_len, phase_len(code));
        cmp(low_len, phase_len(code));
      end
    end
    for (int i = 0; i < 8; i++) begin
      mosi <= ~last_b[i];
      sclk <= 1'b1;
      idle(8);
      sclk <= 1'b0;
      idle(8);
    end
    idle(16);
    chk_settings(last_b);
    send_frame(~last_b, 7);
    chk_settings(last_b);
    results();
  end
endmodule : tb_top
